// ---- rtl/sld_driver.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "sld_defines.svh"

// Function
// [R1] A rising shift clock captures the serial input into stage zero.
// [R2] Each later rising edge moves every stored bit one stage toward cascade.
// [R3] Load high makes latches follow stages; load low holds latches.
// [R4] Controller keeps blanking high while shifting with load tied high.
// [R5] Blanking high turns every source drive off and every pull-down on.
// [R6] Blanking never alters the contents of the latches.
// [R7] Blanking low drives each output from its own latch.
// [R8] Twenty stages, twenty latches, twenty outputs, one per stage.
// [R9] The last stage drives the serial cascade output.
// [R10] Unblanked latch one switches source on; latch zero switches pull-down on.
module sld_driver
    import sld_pkg::*;
#(
    parameter int STAGES = `SLD_STAGES,
    parameter int FIFO_DEPTH = `SLD_FIFO_DEPTH
) (
    input wire logic clock,                // System clock, 100 MHz.
    input wire logic rst_n,                // Synchronous reset, active low.
    input wire logic shiftClk,             // Shift clock from the controller.
    input wire logic serialIn,             // Serial data from the controller.
    input wire logic loadIn,               // Latch load, high is transparent.
    input wire logic blankIn,              // Blanking, high forces outputs off.
    output logic serialOut,                // Cascade output, last stage.
    output logic [STAGES-1:0] sourceOn,    // Source drive on, per output.
    output logic [STAGES-1:0] sinkOn,      // Pull-down on, per output.
    output logic shiftReady,               // Bit buffer has room.
    output logic overrun,                  // Pulse: a bit was dropped, buffer full.
    output logic [STAGES-1:0] latchState   // Current latch contents.
);

    // ----------------------------------------------------------------
    // Drive decode
    // ----------------------------------------------------------------
    function automatic sld_drive_t driveOf(input logic blank, input logic bitVal);
        sld_drive_t d;
        d = DRV_OFF;
        if (blank) begin
            d = DRV_SINK;
        end else if (bitVal) begin
            d = DRV_SOURCE;
        end else begin
            d = DRV_SINK;
        end
        return d;
    endfunction

    // ----------------------------------------------------------------
    // Input sampling and edge detection
    // ----------------------------------------------------------------
    logic clkSample_reg;
    logic clkPrev_reg;
    logic dataSample_reg;
    logic loadSample_reg;
    logic blankSample_reg;
    wire logic shiftRise;

    // Both edge stages reset to the idle low level of the shift clock, so
    // leaving reset fakes no rising edge while the shift clock rests low.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clkSample_reg <= 1'b0;
            clkPrev_reg <= 1'b0;
        end else begin
            clkSample_reg <= shiftClk;
            clkPrev_reg <= clkSample_reg;
        end
    end

    // Blanking starts asserted so the outputs stay off until a real sample
    // of the blanking input has been taken.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dataSample_reg <= 1'b0;
            loadSample_reg <= 1'b0;
            blankSample_reg <= 1'b1;
        end else begin
            dataSample_reg <= serialIn;
            loadSample_reg <= loadIn;
            blankSample_reg <= blankIn;
        end
    end

    // Only the low-to-high transition of the shift clock carries a bit.
    assign shiftRise = clkSample_reg && !clkPrev_reg; // R1

    // ----------------------------------------------------------------
    // Bit buffer between capture and shift register
    // ----------------------------------------------------------------
    wire logic fifoInReady;
    wire logic fifoOutValid;
    wire logic [`SLD_FIFO_WIDTH-1:0] fifoOutData;
    wire logic shiftStep;
    wire logic shiftHold;
    wire logic dropBit;

    sld_fifo #(
        .WIDTH(`SLD_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) bitBuffer (
        .clock(clock),
        .rst_n(rst_n),
        .inData(dataSample_reg), // R1
        .inValid(shiftRise),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(shiftStep)
    );

    // With the latches transparent and outputs live, rippling bits would
    // flash on the outputs; bits wait in the buffer until the controller
    // blanks or drops load.
    assign shiftHold = loadSample_reg && !blankSample_reg; // R4
    assign shiftStep = fifoOutValid && !shiftHold;

    // A rise that finds the buffer full loses its bit; the pulse tells the
    // controller to back off.
    assign dropBit = shiftRise && !fifoInReady;

    // ----------------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------------
    logic [STAGES-1:0] shift_reg;
    wire logic [STAGES-1:0] shift_next;

    // Stage zero takes the new bit; older bits move toward the far end.
    assign shift_next = {shift_reg[STAGES-2:0], fifoOutData[0]}; // R2 R8

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shift_reg <= STAGES'(`SLD_SHIFT_RST);
        end else if (shiftStep) begin
            shift_reg <= shift_next; // R1 R2
        end
    end

    // ----------------------------------------------------------------
    // Latch bank
    // ----------------------------------------------------------------
    logic [STAGES-1:0] latch_reg;
    wire logic [STAGES-1:0] latch_next;

    // Transparency is a clocked follow: the latch trails the shift register by one clock.
    // Blanking does not appear here, so it cannot disturb stored data.
    assign latch_next = loadSample_reg ? shift_reg : latch_reg; // R3 R6

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            latch_reg <= STAGES'(`SLD_LATCH_RST);
        end else begin
            latch_reg <= latch_next; // R3
        end
    end

    // ----------------------------------------------------------------
    // Output drivers
    // ----------------------------------------------------------------
    wire logic [STAGES-1:0] sourceNext;
    wire logic [STAGES-1:0] sinkNext;

    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : gDrive
            wire sld_drive_t drv;
            assign drv = driveOf(blankSample_reg, latch_reg[gi]); // R5 R7 R10
            assign sourceNext[gi] = (drv == DRV_SOURCE); // R10
            assign sinkNext[gi] = (drv == DRV_SINK); // R5
        end
    endgenerate

    // Outputs trail the latch by one clock, so a blanking change reaches the
    // pins two clocks after the blanking input moves.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sourceOn <= STAGES'(`SLD_SOURCE_RST);
        end else begin
            sourceOn <= sourceNext; // R7
        end
    end

    // Every pull-down is on through reset, so the pins rest in the off state.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sinkOn <= STAGES'(`SLD_SINK_RST);
        end else begin
            sinkOn <= sinkNext; // R7
        end
    end

    // ----------------------------------------------------------------
    // Cascade and status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serialOut <= 1'b0;
        end else begin
            serialOut <= shift_reg[STAGES-1]; // R9
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shiftReady <= 1'b0;
            overrun <= 1'b0;
        end else begin
            shiftReady <= fifoInReady;
            overrun <= dropBit;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            latchState <= STAGES'(`SLD_LATCH_RST);
        end else begin
            latchState <= latch_reg;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/sld_defines.svh ----
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SLD_STAGES 20
`define SLD_FIFO_DEPTH 8
`define SLD_FIFO_WIDTH 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLD_SHIFT_RST 20'h00000
`define SLD_LATCH_RST 20'h00000
`define SLD_SOURCE_RST 20'h00000
`define SLD_SINK_RST 20'hfffff

`endif

// ---- rtl/sld_pkg.sv ----
package sld_pkg;

    // Drive state of one output pin: source on, sink on, or neither.
    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_SOURCE,
        DRV_SINK
    } sld_drive_t;

endpackage

// ---- rtl/sld_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module sld_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clock,              // System clock.
    input wire logic rst_n,              // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] inData, // Word to store.
    input wire logic inValid,            // Store request.
    output logic inReady,                // Room for one more word.
    output logic [WIDTH-1:0] outData,    // Oldest stored word.
    output logic outValid,               // A word is waiting.
    input wire logic outReady            // Drain side takes the word.
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;
    logic [PW-1:0] wrPtr_next;
    logic [PW-1:0] rdPtr_next;
    logic [CW-1:0] count_next;
    wire logic doPush;
    wire logic doPop;

    // ----------------------------------------------------------------
    // Handshake and pointer arithmetic
    // ----------------------------------------------------------------
    assign inReady = (count_reg != CW'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    assign wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + PW'(1);
    assign rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + PW'(1);
    assign count_next = count_reg + CW'(doPush) - CW'(doPop);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_next;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_next;
            end
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

endmodule

`default_nettype wire

// ---- verification/sld_driver_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module sld_driver_chk #(
    parameter int STAGES = 20
) (
    input wire logic clock, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic shiftClk, // Shift clock.
    input wire logic serialIn, // Data in.
    input wire logic loadIn, // Load.
    input wire logic blankIn, // Blanking.
    input wire logic serialOut, // Cascade.
    input wire logic [STAGES-1:0] sourceOn, // Sources.
    input wire logic [STAGES-1:0] sinkOn, // Sinks.
    input wire logic shiftReady, // Room.
    input wire logic overrun, // Drop.
    input wire logic [STAGES-1:0] latchState // Latches.
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_blank_off: assert property (blankIn [*3] |-> ##1 (sourceOn == '0 && sinkOn == '1))
        else $error("blanked outputs not off");
    a_unblank_src: assert property (!blankIn [*3] |-> ##1 sourceOn == latchState)
        else $error("source drive differs from latch");
    a_sink_inv: assert property (!blankIn [*3] |-> ##1 sinkOn == ~sourceOn)
        else $error("pull-down not inverse of source");
    a_latch_hold: assert property (!loadIn [*3] |-> ##1 $stable(latchState))
        else $error("latch changed without load");
    a_cascade_tap: assert property ((loadIn && !blankIn) [*5] |-> serialOut == latchState[STAGES-1])
        else $error("cascade not last stage");
    a_ovr_full: assert property (overrun |-> !$past(shiftReady))
        else $error("overrun while room");
    a_ovr_pulse: assert property (overrun |=> !overrun)
        else $error("overrun longer than one cycle");
    a_rst_vals: assert property ($rose(rst_n) |-> (latchState == '0 && sinkOn == '1 && !serialOut))
        else $error("reset state wrong");
endmodule
bind sld_driver sld_driver_chk #(.STAGES(STAGES)) i_chk (.clock(clock), .rst_n(rst_n),
    .shiftClk(shiftClk), .serialIn(serialIn), .loadIn(loadIn), .blankIn(blankIn),
    .serialOut(serialOut), .sourceOn(sourceOn), .sinkOn(sinkOn), .shiftReady(shiftReady),
    .overrun(overrun), .latchState(latchState));
`default_nettype wire

// ---- verification/sld_ctrl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sld_ctrl_model (
    input wire logic clock, // Clock.
    output logic shiftClk, // Shift clock.
    output logic serialIn, // Data.
    output logic loadIn, // Load.
    output logic blankIn // Blanking.
);
    logic strict = 1'b1;
    initial begin
        shiftClk = 1'b0;
        serialIn = 1'b0;
        loadIn = 1'b0;
        blankIn = 1'b0;
    end
    task automatic shift_bit(input logic b);
        @(negedge clock);
        shiftClk = 1'b1;
        serialIn = b;
        @(negedge clock);
        shiftClk = 1'b0;
        serialIn = ~b;
    endtask
    task automatic set_ctl(input logic ld, input logic bl);
        @(negedge clock);
        loadIn = ld;
        blankIn = bl | (strict & ld);
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_sld_driver.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_sld_driver;
    typedef struct packed {logic [19:0] lat; logic [19:0] src; logic [19:0] snk; logic ser;} sld_exp_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sampleReq = 1'b0;
    logic shiftClk, serialIn, loadIn, blankIn, serialOut, shiftReady, overrun;
    logic [19:0] sourceOn, sinkOn, latchState, word;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int ovrCnt = 0;
    sld_exp_t expQ[$];
    sld_exp_t e;
    always #5 clock = ~clock;
    sld_driver #(.STAGES(20), .FIFO_DEPTH(8)) i_dut (.clock(clock), .rst_n(rst_n),
        .shiftClk(shiftClk), .serialIn(serialIn), .loadIn(loadIn), .blankIn(blankIn),
        .serialOut(serialOut), .sourceOn(sourceOn), .sinkOn(sinkOn),
        .shiftReady(shiftReady), .overrun(overrun), .latchState(latchState));
    sld_ctrl_model i_ctrl (.clock(clock), .shiftClk(shiftClk), .serialIn(serialIn),
        .loadIn(loadIn), .blankIn(blankIn));
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic expect_out(input logic [19:0] lat, input logic bl, input logic ser);
        expQ.push_back({lat, bl ? 20'h00000 : lat, bl ? 20'hfffff : ~lat, ser});
        repeat (4) @(negedge clock);
        sampleReq = 1'b1;
        @(negedge clock);
        sampleReq = 1'b0;
    endtask
    task automatic load_word(input logic [19:0] w, input logic bl);
        for (int i = 19; i >= 0; i--) i_ctrl.shift_bit(w[i]);
        repeat (3) @(negedge clock);
        i_ctrl.set_ctl(1'b1, bl);
        i_ctrl.set_ctl(1'b0, bl);
        expect_out(w, bl, w[19]);
    endtask
    always @(posedge clock) begin
        cycles++;
        if (overrun === 1'b1) ovrCnt++;
        if (sampleReq === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            check(latchState, e.lat);
            check(sourceOn, e.src);
            check(sinkOn, e.snk);
            check(20'(serialOut), 20'(e.ser));
        end
        if (cycles > 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        word = 20'($urandom(74235));
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        expect_out(20'h00000, 1'b1, 1'b0);
        for (int k = 0; k < 8; k++) begin
            word = (k == 0) ? 20'hfffff : (k == 1) ? 20'h00001 : 20'($urandom);
            i_ctrl.set_ctl(k == 7, k == 7);
            load_word(word, k == 7);
            i_ctrl.set_ctl(1'b0, 1'b1);
            expect_out(word, 1'b1, word[19]);
            i_ctrl.set_ctl(1'b0, 1'b0);
            expect_out(word, 1'b0, word[19]);
        end
        i_ctrl.strict = 1'b0;
        i_ctrl.set_ctl(1'b1, 1'b0);
        repeat (10) i_ctrl.shift_bit(1'b1);
        repeat (2) @(negedge clock);
        check(20'(shiftReady), 20'h00000);
        check(20'(ovrCnt), 20'h00002);
        i_ctrl.set_ctl(1'b0, 1'b0);
        repeat (12) @(negedge clock);
        check(20'(shiftReady), 20'h00001);
        tally_and_finish();
    end
endmodule
`default_nettype wire
